// ===== hdl/ccs_clock_switch.sv
// CPU clock source selection with delayed switchover and an AHB-Lite slave.
`timescale 1ns/10ps
`include "ccs_params.svh"
module ccs_clock_switch
	import ccs_pkg::*;
#(
	parameter logic [7:0] RATIO_HIGH_ONCHIP = 8'h01,
	parameter logic [7:0] RATIO_ONCHIP_HIGH = 8'h01,
	parameter logic [7:0] RATIO_MAIN_SUB    = 8'h02,
	parameter bit         HIGH_GE_ONCHIP    = 1'b1
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output ccs_src_t         cpuSrc,
	output ccs_src_t         periphSrc,
	output logic      [7:0]  oscMode,
	output logic      [7:0]  oscHalt
);
	// Switch latencies are counted in edges of this clock, which stands for
	// the CPU clock in use before the switch. The ratio parameters must be
	// rounded up by the integrator: a fractional ratio cut short here would
	// let the mux move before the old source has run its full count.
	// Bus timing: zero wait states. A write lands at the edge that closes
	// its data phase; a read returns the register as it stood at the edge
	// that took its address phase. A read whose address phase overlaps the
	// data phase of a write to the same register sees the old value, so a
	// master that wants the new value leaves one idle cycle in between.
	ccs_src_t   selReq;
	ccs_src_t   next_target;
	ccs_src_t   target;
	ccs_state_t state;
	logic [7:0] waitCount;
	logic [7:0] next_latency;
	logic       oscModeLocked;
	logic       wrPending;
	logic [7:0] wrAddr;
	logic       mainChange;
	logic       cpuChange;
	logic [7:0] ctlView;

	// Address phase capture: only word writes are decoded in the data phase.
	// Narrow writes are dropped whole rather than merged into a byte lane.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wrPending <= 1'b0;
			wrAddr    <= 8'h00;
		end else if (hready) begin
			wrPending <= hsel && hwrite && htrans == `CCS_HTRANS_NONSEQ
				&& hsize == `CCS_HSIZE_WORD;
			wrAddr    <= haddr;
		end
	end

	// The slave never stalls and always answers OKAY.
	// Both are still flops so that every output leaves a register.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Selection bits are software state; the switch engine reads them.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			selReq <= '0;
		end else if (wrPending && wrAddr == `CCS_ADDR_CLKCTL) begin
			selReq.mainHigh <= hwdata[`CCS_BIT_MAIN_SEL];
			selReq.cpuSub   <= hwdata[`CCS_BIT_CPU_SEL];
		end
	end

	// Mode register takes the first write after reset and then locks.
	// Later writes are ignored whatever their value; only a reset opens
	// the register again.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			oscMode       <= 8'h00;
			oscModeLocked <= 1'b0;
		end else if (wrPending && wrAddr == `CCS_ADDR_OSCMODE
			&& !oscModeLocked) begin
			oscMode       <= hwdata[7:0];
			oscModeLocked <= 1'b1;
		end
	end

	// Halt bits are software owned; the host must keep the active one on.
	// Nothing here refuses a halt of the running source: the guard lives in
	// software, so a wrong write stops the clock that the CPU uses.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			oscHalt <= `CCS_OSCHALT_RESET;
		end else if (wrPending && wrAddr == `CCS_ADDR_OSCHALT) begin
			oscHalt <= hwdata[7:0] & `CCS_OSCHALT_MASK;
		end
	end

	// One request at a time: the CPU source change wins over the main one,
	// since the main change is invisible while the CPU runs on sub.
	// A pending main change is then taken up on the next idle cycle, with
	// its own latency counted on the clock that runs at that time.
	always_comb begin
		mainChange   = selReq.mainHigh != cpuSrc.mainHigh;
		cpuChange    = selReq.cpuSub != cpuSrc.cpuSub;
		next_target  = cpuSrc;
		next_latency = `CCS_SWITCH_FIXED2;
		if (cpuChange) begin
			next_target.cpuSub = selReq.cpuSub;
			next_latency = selReq.cpuSub ?
				8'(`CCS_SWITCH_ONE + (RATIO_MAIN_SUB << 1))
				: `CCS_SWITCH_FIXED3;
		end else if (mainChange) begin
			next_target.mainHigh = selReq.mainHigh;
			if (selReq.mainHigh) begin
				next_latency = HIGH_GE_ONCHIP ? `CCS_SWITCH_FIXED2
					: 8'(`CCS_SWITCH_ONE + RATIO_ONCHIP_HIGH);
			end else begin
				next_latency = HIGH_GE_ONCHIP ?
					8'(RATIO_HIGH_ONCHIP << 1)
					: `CCS_SWITCH_FIXED2;
			end
		end
	end

	// Switch engine: the old source keeps running while the count drains.
	// The target is frozen when the count starts, so a control write that
	// lands mid-count cannot swap in a change timed for another path.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state     <= ccs_idle_s;
			waitCount <= 8'h00;
			target    <= '0;
			cpuSrc    <= '0;
			periphSrc <= '0;
		end else begin
			unique case (state)
				ccs_idle_s: begin
					if (cpuChange || mainChange) begin
						target    <= next_target;
						waitCount <= next_latency - `CCS_SWITCH_ONE;
						state     <= ccs_wait_s;
					end
				end
				ccs_wait_s: begin
					// The last counted edge moves mux and status together,
					// so the switch lands on its limit and never later.
					if (waitCount <= `CCS_SWITCH_ONE) begin
						cpuSrc    <= target;
						periphSrc <= target;
						state     <= ccs_commit_s;
					end else begin
						waitCount <= waitCount - `CCS_SWITCH_ONE;
					end
				end
				ccs_commit_s: begin
					// One settle cycle on the new source before any further
					// change, so no clock pulse is cut short.
					state <= ccs_idle_s;
				end
			endcase
		end
	end

	// Read view: status bits come from the committed source only.
	always_comb begin
		ctlView = 8'h00;
		ctlView[`CCS_BIT_MAIN_SEL]  = selReq.mainHigh;
		ctlView[`CCS_BIT_CPU_SEL]   = selReq.cpuSub;
		ctlView[`CCS_BIT_MAIN_STAT] = cpuSrc.mainHigh;
		ctlView[`CCS_BIT_CPU_STAT]  = cpuSrc.cpuSub;
	end

	// Read data is registered in the address phase so that it stands
	// through the whole data phase that follows.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && !hwrite
			&& htrans == `CCS_HTRANS_NONSEQ) begin
			unique case (haddr)
				`CCS_ADDR_CLKCTL:  hrdata <= {24'h000000, ctlView};
				`CCS_ADDR_OSCMODE: hrdata <= {24'h000000, oscMode};
				`CCS_ADDR_OSCHALT: hrdata <= {24'h000000, oscHalt};
				default:           hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // ccs_clock_switch

// ===== hdl/ccs_params.svh
// Register offsets, field positions, reset values and switchover counts.
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
`define CCS_ADDR_CLKCTL      8'h00
`define CCS_ADDR_OSCMODE     8'h04
`define CCS_ADDR_OSCHALT     8'h08
`define CCS_BIT_MAIN_SEL     4
`define CCS_BIT_MAIN_STAT    5
`define CCS_BIT_CPU_SEL      6
`define CCS_BIT_CPU_STAT     7
`define CCS_BIT_MAIN_PIN     0
`define CCS_BIT_MAIN_EXT     1
`define CCS_BIT_SUB_PIN      2
`define CCS_BIT_SUB_EXT      3
`define CCS_BIT_ONCHIP_HALT  0
`define CCS_BIT_MAIN_HALT    1
`define CCS_BIT_SUB_HALT     2
`define CCS_OSCHALT_RESET    8'h06
`define CCS_SWITCH_FIXED2    8'h02
`define CCS_SWITCH_FIXED3    8'h03
`define CCS_SWITCH_ONE       8'h01
`define CCS_OSCHALT_MASK     8'h07
`define CCS_HTRANS_NONSEQ    2'h2
`define CCS_HSIZE_WORD       3'h2
`endif

// ===== hdl/ccs_pkg.sv
// Types shared by the clock source switch.
package ccs_pkg;
	typedef struct packed {
		logic       cpuSub;
		logic       mainHigh;
	} ccs_src_t;
	typedef enum logic [2:0] {
		ccs_idle_s   = 3'b001,
		ccs_wait_s   = 3'b010,
		ccs_commit_s = 3'b100
	} ccs_state_t;
endpackage

// ===== tb/ccs_clock_switch_asserts.sv
// Checker for switch latency, status reads and mode lock of the clock switch.
`timescale 1ns/10ps
`include "ccs_params.svh"
module ccs_clock_switch_asserts
	import ccs_pkg::*;
#(
	parameter logic [7:0] RATIO_HIGH_ONCHIP = 8'h01,
	parameter logic [7:0] RATIO_ONCHIP_HIGH = 8'h01,
	parameter logic [7:0] RATIO_MAIN_SUB    = 8'h02,
	parameter bit         HIGH_GE_ONCHIP    = 1'b1
) (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire ccs_src_t    cpuSrc,
	input wire ccs_src_t    periphSrc,
	input wire logic [7:0]  oscMode
);
	logic       dPh;
	logic       dWr;
	logic [7:0] dAddr;
	logic [7:0] sinceWr;
	logic       modeDone;
	wire        ctlWr = dPh && dWr && hready && dAddr == `CCS_ADDR_CLKCTL;
	// Data phase tracking; hready is always high, so one cycle per phase.
	always_ff @(posedge clk_sys) begin
		dPh <= rst_n && hready && hsel && htrans == `CCS_HTRANS_NONSEQ;
		dWr <= hwrite;
		dAddr <= haddr;
	end
	// Edges since the last control write, held at the top to avoid wrap.
	always_ff @(posedge clk_sys) begin
		if (!rst_n || ctlWr) begin
			sinceWr <= 8'h00;
		end else if (sinceWr != 8'hff) begin
			sinceWr <= sinceWr + 8'h01;
		end
	end
	// Set once the mode register has taken its single write.
	always_ff @(posedge clk_sys) begin
		modeDone <= rst_n && (modeDone || dPh && dWr && hready
			&& dAddr == `CCS_ADDR_OSCMODE);
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_keep;
		$stable(cpuSrc)[*2];
	endsequence
	property p_periph; periphSrc == cpuSrc; endproperty
	property p_keep; ctlWr |=> s_keep; endproperty
	property p_sub; $rose(cpuSrc.cpuSub) |-> sinceWr == 8'h01 + 2 * RATIO_MAIN_SUB;
	endproperty
	property p_main; $fell(cpuSrc.cpuSub) |-> sinceWr == 8'h03; endproperty
	property p_up; $rose(cpuSrc.mainHigh) |-> sinceWr ==
		(HIGH_GE_ONCHIP ? 8'h02 : 8'h01 + RATIO_ONCHIP_HIGH); endproperty
	property p_down; $fell(cpuSrc.mainHigh) |-> sinceWr ==
		(HIGH_GE_ONCHIP ? 2 * RATIO_HIGH_ONCHIP : 8'h02); endproperty
	property p_status; dPh && !dWr && hready && dAddr == `CCS_ADDR_CLKCTL
		|-> {hrdata[7], hrdata[5]} == $past(cpuSrc); endproperty
	property p_mode; modeDone |-> ##1 $stable(oscMode); endproperty
	a_periph: assert property (p_periph)
		else $error("peripheral source differs from CPU source");
	a_keep: assert property (p_keep)
		else $error("source changed right after the control write");
	a_sub: assert property (p_sub)
		else $error("main to sub latency wrong");
	a_main: assert property (p_main)
		else $error("sub to main latency wrong");
	a_up: assert property (p_up)
		else $error("main up latency wrong");
	a_down: assert property (p_down)
		else $error("main down latency wrong");
	a_status: assert property (p_status)
		else $error("status bits do not show the committed source");
	a_mode: assert property (p_mode)
		else $error("mode register changed after its single write");
endmodule // ccs_clock_switch_asserts

bind ccs_clock_switch ccs_clock_switch_asserts #(
	.RATIO_HIGH_ONCHIP(RATIO_HIGH_ONCHIP),
	.RATIO_ONCHIP_HIGH(RATIO_ONCHIP_HIGH),
	.RATIO_MAIN_SUB(RATIO_MAIN_SUB),
	.HIGH_GE_ONCHIP(HIGH_GE_ONCHIP)
) uChk (
	.clk_sys  (clk_sys),
	.rst_n    (rst_n),
	.hsel     (hsel),
	.haddr    (haddr),
	.htrans   (htrans),
	.hwrite   (hwrite),
	.hready   (hready),
	.hrdata   (hrdata),
	.cpuSrc   (cpuSrc),
	.periphSrc(periphSrc),
	.oscMode  (oscMode)
);

// ===== tb/ccs_clock_switch_tb_top.sv
// Directed bus test bench for the clock source switch.
`timescale 1ns/10ps
`include "ccs_params.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	errTotal++; $display("ERROR at %0t got %h exp %h", $time, got, exp); \
	end end
module ccs_clock_switch_tb_top
	import ccs_pkg::*;
;
	localparam logic [7:0] MAIN_SUB    = 8'h02;
	localparam logic [7:0] HIGH_ONCHIP = 8'h01;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = `CCS_HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	ccs_src_t    cpuSrc;
	ccs_src_t    periphSrc;
	logic [7:0]  oscMode;
	logic [7:0]  oscHalt;
	logic [31:0] rd;
	int          errTotal = 0;
	int          comparisons = 0;
	int          n;
	// The single slave's hreadyout closes the loop as the bus hready.
	ccs_clock_switch #(
		.RATIO_HIGH_ONCHIP(HIGH_ONCHIP),
		.RATIO_MAIN_SUB   (MAIN_SUB)
	) DUT (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.hsel     (hsel),
		.haddr    (haddr),
		.htrans   (htrans),
		.hwrite   (hwrite),
		.hsize    (hsize),
		.hwdata   (hwdata),
		.hready   (hreadyout),
		.hrdata   (hrdata),
		.hreadyout(hreadyout),
		.hresp    (hresp),
		.cpuSrc   (cpuSrc),
		.periphSrc(periphSrc),
		.oscMode  (oscMode),
		.oscHalt  (oscHalt)
	);
	initial forever #20 clk_sys = ~clk_sys;
	// One single word transfer; read data is taken at the data phase edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= `CCS_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask
	// Writes the control word, counts edges until the new source shows.
	// Values are read before the edge settles, so a switch made at edge
	// lat after the write is first seen one edge later.
	task automatic sw(input logic [7:0] v, input ccs_src_t e, input int lat);
		bus(1'b1, `CCS_ADDR_CLKCTL, {24'h0, v});
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cpuSrc !== e && n < 40);
		`CHK(n, lat + 1)
		`CHK(periphSrc, e)
		bus(1'b0, `CCS_ADDR_CLKCTL, 32'h0);
		`CHK(rd, {24'h0, e.cpuSub, v[6], e.mainHigh, v[4], 4'h0})
	endtask
	task automatic reportAndStop();
		$display("comparisons %0d errors %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence; status bits 7 and 5 are written as ones in one step.
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(1'b0, `CCS_ADDR_OSCHALT, 32'h0);
		`CHK(rd, 32'h6)
		bus(1'b1, `CCS_ADDR_OSCMODE, 32'h5);
		bus(1'b1, `CCS_ADDR_OSCMODE, 32'ha);
		bus(1'b1, `CCS_ADDR_OSCHALT, 32'h0);
		`CHK(oscMode, 8'h05)
		bus(1'b0, `CCS_ADDR_OSCMODE, 32'h0);
		`CHK(rd, 32'h5)
		sw(8'h10, 2'h1, 2);
		bus(1'b1, `CCS_ADDR_OSCHALT, 32'h1);
		sw(8'h50, 2'h3, 1 + 2 * MAIN_SUB);
		sw(8'hb0, 2'h1, 3);
		bus(1'b1, `CCS_ADDR_OSCHALT, 32'h0);
		sw(8'h00, 2'h0, 2 * HIGH_ONCHIP);
		bus(1'b1, `CCS_ADDR_OSCHALT, 32'h6);
		bus(1'b0, `CCS_ADDR_OSCHALT, 32'h0);
		`CHK(rd, 32'h6)
		`CHK(oscHalt, 8'h06)
		// Second reset in mid-run reopens the mode register.
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(1'b0, `CCS_ADDR_OSCMODE, 32'h0);
		`CHK(rd, 32'h0)
		bus(1'b1, `CCS_ADDR_OSCMODE, 32'hf);
		bus(1'b1, `CCS_ADDR_OSCHALT, 32'h0);
		sw(8'h40, 2'h2, 1 + 2 * MAIN_SUB);
		sw(8'h00, 2'h0, 3);
		bus(1'b0, `CCS_ADDR_OSCMODE, 32'h0);
		`CHK(rd, 32'hf)
		reportAndStop();
	end
	// The run needs about eighty cycles; far more means a hang.
	initial begin
		repeat (2000) @(posedge clk_sys);
		errTotal++;
		reportAndStop();
	end
endmodule // ccs_clock_switch_tb_top
